// ==== verilog/ictim_pkg.sv ====
// Package: operation codes and cycle-count constants for the instruction timing block
package ictim_pkg;

	// Operation classes accepted on the request port
	localparam logic [5:0] OP_BRANCH_COND = 6'h00;
	localparam logic [5:0] OP_UNCOND_BRANCH = 6'h01;
	localparam logic [5:0] OP_BRANCH_SUB = 6'h02;
	localparam logic [5:0] OP_DEC_BRANCH_LOOP = 6'h03;
	localparam logic [5:0] OP_BOUNDS_CHECK = 6'h04;
	localparam logic [5:0] OP_SW_TRAP = 6'h05;
	localparam logic [5:0] OP_OVERFLOW_TRAP = 6'h06;
	localparam logic [5:0] OP_JUMP = 6'h07;
	localparam logic [5:0] OP_SUB_JUMP = 6'h08;
	localparam logic [5:0] OP_ADDR_LOAD = 6'h09;
	localparam logic [5:0] OP_ADDR_PUSH = 6'h0a;
	localparam logic [5:0] OP_MULTI_LOAD = 6'h0b;
	localparam logic [5:0] OP_MULTI_STORE = 6'h0c;
	localparam logic [5:0] OP_EXTENDED = 6'h0d;
	localparam logic [5:0] OP_MEM_COMPARE = 6'h0e;
	localparam logic [5:0] OP_DECIMAL = 6'h0f;
	localparam logic [5:0] OP_IMM_TO_STATUS = 6'h10;
	localparam logic [5:0] OP_RET_EXCEPTION = 6'h11;
	localparam logic [5:0] OP_RET_SUB = 6'h12;
	localparam logic [5:0] OP_STOP = 6'h13;
	localparam logic [5:0] OP_NO_OPERATION = 6'h14;
	localparam logic [5:0] OP_RESET_LINE = 6'h15;
	localparam logic [5:0] OP_FRAME_LINK = 6'h16;
	localparam logic [5:0] OP_FRAME_UNLINK = 6'h17;
	localparam logic [5:0] OP_LOAD_STATUS = 6'h18;
	localparam logic [5:0] OP_READ_STATUS = 6'h19;
	localparam logic [5:0] OP_USP_MOVE = 6'h1a;
	localparam logic [5:0] OP_PERIPH_MOVE = 6'h1b;
	localparam logic [5:0] OP_EXC_BUS_ERROR = 6'h1c;
	localparam logic [5:0] OP_EXC_INTERRUPT = 6'h1d;
	localparam logic [5:0] OP_EXC_GENERIC = 6'h1e;
	localparam logic [5:0] OP_EXC_DIV_ZERO = 6'h1f;

	// Size codes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	// Bus cycle length in clocks, and width of the clock total
	localparam logic [3:0] BUS_CYCLE_CLKS = 4'h4;
	localparam int CW = 12;
	localparam int BW = 8;

	// Start-up sequence after reset and halt are released
	localparam logic [CW-1:0] STARTUP_CLKS = 12'h040;
	localparam logic [BW-1:0] STARTUP_READS = 8'h0c;

endpackage

// ==== verilog/ictim_table.sv ====
// Lookup of total clocks, reads and writes for one operation class
`timescale 1ns/1ns
module ictim_table (
	input wire logic [5:0] op_in,
	input wire logic [1:0] size_in,
	input wire logic alt_in,
	input wire logic cond_in,
	input wire logic mem_in,
	input wire logic [4:0] nregs_in,
	output logic [ictim_pkg::CW-1:0] clks_out,
	output logic [ictim_pkg::BW-1:0] reads_out,
	output logic [ictim_pkg::BW-1:0] writes_out,
	output logic add_ea_out
);

	logic [ictim_pkg::CW-1:0] n8;
	logic [ictim_pkg::CW-1:0] n16;
	logic [ictim_pkg::BW-1:0] n2;
	logic [ictim_pkg::BW-1:0] n4;
	logic lng;

	// Register-count scaled terms for the multi-register moves
	assign n8 = {4'h0, nregs_in, 3'h0};
	assign n16 = {3'h0, nregs_in, 4'h0};
	assign n2 = {2'h0, nregs_in, 1'h0};
	assign n4 = {1'h0, nregs_in, 2'h0};
	assign lng = (size_in == ictim_pkg::SZ_LONG);

	// Per-class totals; alt selects the second table column, cond the taken/true case
	always_comb begin
		clks_out = 12'h008;
		reads_out = 8'h02;
		writes_out = 8'h00;
		add_ea_out = 1'b0;
		unique case (op_in)
			ictim_pkg::OP_BRANCH_COND: begin
				if (cond_in) begin
					clks_out = 12'h012; reads_out = 8'h04;
				end else if (size_in == ictim_pkg::SZ_BYTE) begin
					clks_out = 12'h00c; reads_out = 8'h02;
				end else begin
					clks_out = 12'h014; reads_out = 8'h04;
				end
			end
			ictim_pkg::OP_UNCOND_BRANCH: begin
				clks_out = 12'h012; reads_out = 8'h04;
			end
			ictim_pkg::OP_BRANCH_SUB: begin
				clks_out = 12'h022; reads_out = 8'h04; writes_out = 8'h04;
			end
			ictim_pkg::OP_DEC_BRANCH_LOOP: begin
				// alt set means the loop branches back
				if (alt_in) begin
					clks_out = 12'h012; reads_out = 8'h04;
				end else if (cond_in) begin
					clks_out = 12'h014; reads_out = 8'h04;
				end else begin
					clks_out = 12'h01a; reads_out = 8'h06;
				end
			end
			ictim_pkg::OP_BOUNDS_CHECK: begin
				if (cond_in) begin
					clks_out = 12'h044; reads_out = 8'h08; writes_out = 8'h06; add_ea_out = 1'b1;
				end else begin
					clks_out = 12'h00e; reads_out = 8'h02;
				end
			end
			ictim_pkg::OP_SW_TRAP: begin
				clks_out = 12'h03e; reads_out = 8'h08; writes_out = 8'h06;
			end
			ictim_pkg::OP_OVERFLOW_TRAP: begin
				if (cond_in) begin
					clks_out = 12'h042; reads_out = 8'h0a; writes_out = 8'h06;
				end else begin
					clks_out = 12'h008; reads_out = 8'h02;
				end
			end
			ictim_pkg::OP_JUMP: begin
				clks_out = 12'h010; reads_out = 8'h04;
			end
			ictim_pkg::OP_SUB_JUMP: begin
				clks_out = 12'h020; reads_out = 8'h04; writes_out = 8'h04;
			end
			ictim_pkg::OP_ADDR_LOAD: begin
				clks_out = 12'h008; reads_out = 8'h02;
			end
			ictim_pkg::OP_ADDR_PUSH: begin
				clks_out = 12'h018; reads_out = 8'h02; writes_out = 8'h04;
			end
			ictim_pkg::OP_MULTI_LOAD: begin
				clks_out = 12'h018 + (lng ? n16 : n8);
				reads_out = 8'h06 + (lng ? n4 : n2);
			end
			ictim_pkg::OP_MULTI_STORE: begin
				clks_out = 12'h010 + (lng ? n16 : n8);
				reads_out = 8'h04;
				writes_out = lng ? n4 : n2;
			end
			ictim_pkg::OP_EXTENDED: begin
				if (!mem_in) begin
					clks_out = lng ? 12'h00c : 12'h008;
				end else if (size_in == ictim_pkg::SZ_BYTE) begin
					clks_out = 12'h016; reads_out = 8'h04; writes_out = 8'h01;
				end else if (!lng) begin
					clks_out = 12'h032; reads_out = 8'h06; writes_out = 8'h02;
				end else begin
					clks_out = 12'h03a; reads_out = 8'h0a; writes_out = 8'h04;
				end
			end
			ictim_pkg::OP_MEM_COMPARE: begin
				if (size_in == ictim_pkg::SZ_BYTE) begin
					clks_out = 12'h010; reads_out = 8'h04;
				end else if (!lng) begin
					clks_out = 12'h018; reads_out = 8'h06;
				end else begin
					clks_out = 12'h028; reads_out = 8'h0a;
				end
			end
			ictim_pkg::OP_DECIMAL: begin
				if (mem_in) begin
					clks_out = 12'h014; reads_out = 8'h04; writes_out = 8'h01;
				end else begin
					clks_out = 12'h00a;
				end
			end
			ictim_pkg::OP_IMM_TO_STATUS: begin
				clks_out = 12'h020; reads_out = 8'h06;
			end
			ictim_pkg::OP_RET_EXCEPTION: begin
				clks_out = 12'h028; reads_out = 8'h0a;
			end
			ictim_pkg::OP_RET_SUB: begin
				clks_out = 12'h020; reads_out = 8'h08;
			end
			ictim_pkg::OP_STOP: begin
				clks_out = 12'h004; reads_out = 8'h00;
			end
			ictim_pkg::OP_NO_OPERATION: begin
				clks_out = 12'h008;
			end
			ictim_pkg::OP_RESET_LINE: begin
				clks_out = 12'h088;
			end
			ictim_pkg::OP_FRAME_LINK: begin
				clks_out = 12'h020; reads_out = 8'h04; writes_out = 8'h04;
			end
			ictim_pkg::OP_FRAME_UNLINK: begin
				clks_out = 12'h018; reads_out = 8'h06;
			end
			ictim_pkg::OP_LOAD_STATUS: begin
				clks_out = 12'h012; reads_out = 8'h04; add_ea_out = mem_in;
			end
			ictim_pkg::OP_READ_STATUS: begin
				if (mem_in) begin
					clks_out = 12'h010; writes_out = 8'h02; add_ea_out = 1'b1;
				end else begin
					clks_out = 12'h00a;
				end
			end
			ictim_pkg::OP_USP_MOVE: begin
				clks_out = 12'h008;
			end
			ictim_pkg::OP_PERIPH_MOVE: begin
				// alt set means register to memory
				clks_out = lng ? 12'h020 : 12'h018;
				if (alt_in) begin
					reads_out = 8'h04; writes_out = lng ? 8'h04 : 8'h02;
				end else begin
					reads_out = lng ? 8'h08 : 8'h06;
				end
			end
			ictim_pkg::OP_EXC_BUS_ERROR: begin
				clks_out = 12'h05e; reads_out = 8'h08; writes_out = 8'h0e;
			end
			ictim_pkg::OP_EXC_INTERRUPT: begin
				clks_out = 12'h048; reads_out = 8'h09; writes_out = 8'h06;
			end
			ictim_pkg::OP_EXC_GENERIC: begin
				clks_out = 12'h03e; reads_out = 8'h08; writes_out = 8'h06;
			end
			ictim_pkg::OP_EXC_DIV_ZERO: begin
				clks_out = 12'h042; reads_out = 8'h08; writes_out = 8'h06; add_ea_out = 1'b1;
			end
			default: begin
				clks_out = 12'h008;
			end
		endcase
	end

endmodule // ictim_table

// ==== verilog/ictim_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module ictim_sync #(
	parameter int W = 2
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;

	// First stage feeds only the second
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= d_in;
			s2_r <= s1_r;
		end
	end

	assign q_out = s2_r;

endmodule // ictim_sync

// ==== verilog/ictim_core.sv ====
// Cycle-accurate bus occupancy sequencer for the processor timing model
`timescale 1ns/1ns
module ictim_core (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic reset_pin_n_in,
	input wire logic halt_pin_n_in,
	input wire logic req_in,
	input wire logic [5:0] op_in,
	input wire logic [1:0] size_in,
	input wire logic alt_in,
	input wire logic cond_in,
	input wire logic mem_in,
	input wire logic index_long_in,
	input wire logic [4:0] nregs_in,
	input wire logic [ictim_pkg::CW-1:0] ea_clks_in,
	input wire logic [ictim_pkg::BW-1:0] ea_reads_in,
	input wire logic wait_in,
	output logic ready_out,
	output logic running_out,
	output logic bus_read_out,
	output logic bus_write_out,
	output logic bus_idle_out,
	output logic done_out,
	output logic [ictim_pkg::CW-1:0] total_out
);

	typedef enum logic [4:0] {
		ICT_HOLD = 5'h01,
		ICT_START = 5'h02,
		ICT_IDLE = 5'h04,
		ICT_BUSY = 5'h08,
		ICT_WRAP = 5'h10
	} ictim_state_t;

	ictim_state_t state_r, state_nxt;
	logic [ictim_pkg::CW-1:0] clk_left_r, clk_left_nxt;
	logic [ictim_pkg::BW-1:0] rd_left_r, rd_left_nxt;
	logic [ictim_pkg::BW-1:0] wr_left_r, wr_left_nxt;
	logic [3:0] phase_r, phase_nxt;
	logic cyc_write_r, cyc_write_nxt;
	logic [ictim_pkg::CW-1:0] total_r, total_nxt;
	logic ready_r, ready_nxt;
	logic running_r, running_nxt;
	logic rd_o_r, rd_o_nxt;
	logic wr_o_r, wr_o_nxt;
	logic idle_o_r, idle_o_nxt;
	logic done_r, done_nxt;
	logic [1:0] pins_sync;
	logic [ictim_pkg::CW-1:0] t_clks;
	logic [ictim_pkg::BW-1:0] t_reads;
	logic [ictim_pkg::BW-1:0] t_writes;
	logic t_add_ea;
	logic [ictim_pkg::CW-1:0] bus_clks;

	// Reset and halt pins come from outside the clock domain
	ictim_sync #(.W(2)) u_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.d_in({reset_pin_n_in, halt_pin_n_in}),
		.q_out(pins_sync)
	);

	// Timing lookup; the index size is deliberately not an input of it
	ictim_table u_table (
		.op_in(op_in),
		.size_in(size_in),
		.alt_in(alt_in),
		.cond_in(cond_in),
		.mem_in(mem_in),
		.nregs_in(nregs_in),
		.clks_out(t_clks),
		.reads_out(t_reads),
		.writes_out(t_writes),
		.add_ea_out(t_add_ea)
	);

	// Clocks spent in bus cycles for a given count of cycles
	function automatic logic [ictim_pkg::CW-1:0] bus_time(input logic [ictim_pkg::BW-1:0] cycles);
		bus_time = {2'h0, cycles, 2'h0};
	endfunction

	// Index width accepted but unused: indexed modes cost the same either way
	logic unused_index;
	assign unused_index = index_long_in;

	// Sequencer: bus cycles first, internal idle clocks after them
	always_comb begin
		state_nxt = state_r;
		clk_left_nxt = clk_left_r;
		rd_left_nxt = rd_left_r;
		wr_left_nxt = wr_left_r;
		phase_nxt = phase_r;
		cyc_write_nxt = cyc_write_r;
		total_nxt = total_r;
		ready_nxt = 1'b0;
		running_nxt = running_r;
		rd_o_nxt = 1'b0;
		wr_o_nxt = 1'b0;
		idle_o_nxt = 1'b0;
		done_nxt = 1'b0;
		bus_clks = '0;
		unique case (state_r)
			ICT_HOLD: begin
				// Wait until both pins are first seen negated
				if (pins_sync == 2'h3) begin
					state_nxt = ICT_START;
					clk_left_nxt = ictim_pkg::STARTUP_CLKS;
					rd_left_nxt = ictim_pkg::STARTUP_READS;
					wr_left_nxt = '0;
					phase_nxt = '0;
					total_nxt = '0;
				end
			end
			ICT_START, ICT_BUSY: begin
				if (phase_r != 4'h0) begin
					// Inside a bus cycle; wait states stretch the last clock
					rd_o_nxt = !cyc_write_r;
					wr_o_nxt = cyc_write_r;
					total_nxt = total_r + 12'h001;
					if (phase_r == ictim_pkg::BUS_CYCLE_CLKS && wait_in) begin
						phase_nxt = phase_r;
					end else begin
						phase_nxt = (phase_r == ictim_pkg::BUS_CYCLE_CLKS) ? 4'h0 : phase_r + 4'h1;
						clk_left_nxt = clk_left_r - 12'h001;
					end
				end else if (rd_left_r != '0 || wr_left_r != '0) begin
					// Open a new cycle; reads before writes
					cyc_write_nxt = (rd_left_r == '0);
					if (rd_left_r != '0) begin
						rd_left_nxt = rd_left_r - 8'h01;
					end else begin
						wr_left_nxt = wr_left_r - 8'h01;
					end
					rd_o_nxt = (rd_left_r != '0);
					wr_o_nxt = (rd_left_r == '0);
					phase_nxt = 4'h2;
					clk_left_nxt = clk_left_r - 12'h001;
					total_nxt = total_r + 12'h001;
				end else if (clk_left_r != '0) begin
					// Remaining clocks drive no bus transfer
					idle_o_nxt = 1'b1;
					clk_left_nxt = clk_left_r - 12'h001;
					total_nxt = total_r + 12'h001;
				end else begin
					state_nxt = ICT_WRAP;
				end
				if (phase_r == 4'h0 && rd_left_r == '0 && wr_left_r == '0 && clk_left_r == '0) begin
					done_nxt = 1'b1;
					running_nxt = (state_r == ICT_START) ? 1'b1 : running_r;
				end
			end
			ICT_WRAP: begin
				state_nxt = ICT_IDLE;
				ready_nxt = 1'b1;
			end
			ICT_IDLE: begin
				ready_nxt = 1'b1;
				if (req_in) begin
					// Totals include addressing time when flagged
					state_nxt = ICT_BUSY;
					ready_nxt = 1'b0;
					if (t_add_ea) begin
						clk_left_nxt = t_clks + ea_clks_in;
						rd_left_nxt = t_reads + ea_reads_in;
					end else begin
						clk_left_nxt = t_clks;
						rd_left_nxt = t_reads;
					end
					wr_left_nxt = t_writes;
					phase_nxt = '0;
					total_nxt = '0;
				end
			end
			default: begin
				state_nxt = ICT_HOLD;
			end
		endcase
		if (!pins_sync[1]) begin
			// External reset restarts the start-up sequence
			state_nxt = ICT_HOLD;
			running_nxt = 1'b0;
			ready_nxt = 1'b0;
		end
	end

	// Register stage for the sequencer and its outputs
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= ICT_HOLD;
			clk_left_r <= '0;
			rd_left_r <= '0;
			wr_left_r <= '0;
			phase_r <= '0;
			cyc_write_r <= 1'b0;
			total_r <= '0;
			ready_r <= 1'b0;
			running_r <= 1'b0;
			rd_o_r <= 1'b0;
			wr_o_r <= 1'b0;
			idle_o_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			clk_left_r <= clk_left_nxt;
			rd_left_r <= rd_left_nxt;
			wr_left_r <= wr_left_nxt;
			phase_r <= phase_nxt;
			cyc_write_r <= cyc_write_nxt;
			total_r <= total_nxt;
			ready_r <= ready_nxt;
			running_r <= running_nxt;
			rd_o_r <= rd_o_nxt;
			wr_o_r <= wr_o_nxt;
			idle_o_r <= idle_o_nxt;
			done_r <= done_nxt;
		end
	end

	assign ready_out = ready_r;
	assign running_out = running_r;
	assign bus_read_out = rd_o_r;
	assign bus_write_out = wr_o_r;
	assign bus_idle_out = idle_o_r;
	assign done_out = done_r;
	assign total_out = total_r;

endmodule // ictim_core

// ==== sim/ictim_bus_model.sv ====
// Bus partner: memory that answers each cycle, optionally with wait states
`timescale 1ns/1ns
module ictim_bus_model (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic slow_in,
	input wire logic bus_read_in,
	input wire logic bus_write_in,
	output logic wait_out
);
	logic wait_r;
	logic wait_nxt;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	// Slow memory stalls one clock in three, so stalls drift across cycle positions
	always_comb begin
		cnt_nxt = (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
		if (bus_read_in || bus_write_in) begin
			wait_nxt = slow_in && (cnt_r == 2'h0);
		end else begin
			wait_nxt = !wait_r; // Undriven between cycles, so the line wanders
		end
	end
	// State registers
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wait_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			wait_r <= wait_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	assign wait_out = wait_r;
endmodule // ictim_bus_model

// ==== sim/ictim_core_checker.sv ====
// Concurrent checks on the timing sequencer ports
`timescale 1ns/1ns
module ictim_core_checker (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic reset_pin_n_in,
	input wire logic halt_pin_n_in,
	input wire logic req_in,
	input wire logic ready_out,
	input wire logic running_out,
	input wire logic bus_read_out,
	input wire logic bus_write_out,
	input wire logic bus_idle_out,
	input wire logic done_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// A request taken, and any bus or idle strobe
	sequence taken_s;
		req_in && ready_out && running_out;
	endsequence
	sequence strobe_s;
		bus_read_out || bus_write_out || bus_idle_out;
	endsequence
	strobe_onehot_a: assert property ($onehot0({bus_read_out, bus_write_out, bus_idle_out}))
		else $error("strobes overlap");
	take_busy_a: assert property (taken_s |=> !ready_out)
		else $error("ready stayed after take");
	first_strobe_a: assert property (taken_s |-> ##2 strobe_s)
		else $error("no strobe two clocks after take");
	read_len_a: assert property ($rose(bus_read_out) |-> bus_read_out [*4])
		else $error("read cycle shorter than four clocks");
	write_len_a: assert property ($rose(bus_write_out) |-> bus_write_out [*4])
		else $error("write cycle shorter than four clocks");
	write_order_a: assert property ($fell(bus_write_out) |-> !bus_read_out [*3])
		else $error("read after writes");
	ready_quiet_a: assert property (ready_out |-> !(bus_read_out || bus_write_out))
		else $error("bus busy while ready");
	done_pulse_a: assert property (done_out |=> !done_out)
		else $error("done longer than one clock");
	startup_end_a: assert property ($rose(running_out) |-> $past(bus_idle_out))
		else $error("start-up did not end on idle clocks");
	halt_hold_a: assert property ((!halt_pin_n_in && !running_out) [*4] |-> !bus_read_out)
		else $error("start-up reads while halted");
	pin_reset_a: assert property (!reset_pin_n_in [*5] |-> !running_out)
		else $error("still running under pin reset");
endmodule // ictim_core_checker
bind ictim_core ictim_core_checker u_chk (.clk_in, .rstn_in, .reset_pin_n_in, .halt_pin_n_in, .req_in,
	.ready_out, .running_out, .bus_read_out, .bus_write_out, .bus_idle_out, .done_out);

// ==== sim/instruction_cycle_timing_tb.sv ====
// Bench for the timing sequencer: class totals, bus mix, start-up and pin reset
`timescale 1ns/1ns
module instruction_cycle_timing_tb;
	typedef struct {logic [11:0] clks; int rd; int wr; logic slow;} ictim_exp_t;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic rpin_n = 1'b1;
	logic hpin_n = 1'b0;
	logic req = 1'b0;
	logic alt = 1'b0;
	logic cond = 1'b0;
	logic mem = 1'b0;
	logic idx = 1'b0;
	logic slow = 1'b0;
	logic run_q = 1'b0;
	logic [5:0] op = 6'h00;
	logic [1:0] sz = 2'h0;
	logic [4:0] nr = 5'h00;
	logic [11:0] eac = 12'h000;
	logic [7:0] ear = 8'h00;
	logic wait_w, ready, running, brd, bwr, bidl, done;
	logic [11:0] total;
	int n_mismatch = 0;
	int check_count = 0;
	int rd_c = 0;
	int wr_c = 0;
	int id_c = 0;
	int cyc = 0;
	ictim_exp_t expq[$];
	ictim_core u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .reset_pin_n_in(rpin_n), .halt_pin_n_in(hpin_n),
		.req_in(req), .op_in(op), .size_in(sz), .alt_in(alt), .cond_in(cond), .mem_in(mem), .index_long_in(idx),
		.nregs_in(nr), .ea_clks_in(eac), .ea_reads_in(ear), .wait_in(wait_w), .ready_out(ready),
		.running_out(running), .bus_read_out(brd), .bus_write_out(bwr), .bus_idle_out(bidl), .done_out(done),
		.total_out(total));
	ictim_bus_model u_mem (.clk_in(clk_in), .rstn_in(rstn_in), .slow_in(slow), .bus_read_in(brd),
		.bus_write_in(bwr), .wait_out(wait_w));
	// 50 MHz clock
	initial begin
		forever #10 clk_in = ~clk_in;
	end
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Ceiling far above the whole sequence; a hang ends the run as a failure
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// Tally strobes; compare at each completion and when start-up ends
	always @(posedge clk_in) begin
		ictim_exp_t e;
		rd_c += int'(brd === 1'b1);
		wr_c += int'(bwr === 1'b1);
		id_c += int'(bidl === 1'b1);
		// Start-up end also pulses done, but no request was queued for it
		if (running === 1'b1 && run_q !== 1'b1) begin
			check(12'(rd_c), 12'h030);
			check(12'(rd_c + wr_c + id_c), 12'h040);
			check(total, 12'h040);
		end else if (done === 1'b1) begin
			if (expq.size() == 0) begin
				n_mismatch++;
				$display("Error t=%0t got=%h exp=%h", $time, total, 12'h000);
			end else begin
				e = expq.pop_front();
				check(total, 12'(rd_c + wr_c + id_c));
				if (e.slow) begin
					check(12'(total > e.clks), 12'h001);
				end else begin
					check(total, e.clks);
					check(12'(rd_c), 12'(4 * e.rd));
					check(12'(wr_c), 12'(4 * e.wr));
				end
			end
		end
		// Counts restart after each result, and while either reset holds the core
		if (done === 1'b1 || (running === 1'b1 && run_q !== 1'b1) || rstn_in !== 1'b1 || rpin_n !== 1'b1) begin
			rd_c = 0;
			wr_c = 0;
			id_c = 0;
		end
		run_q = running;
	end
	// One request: wait for ready, present the class, note the expected bus use
	task automatic run(input logic [5:0] o, input int s, a, c, m, n, clks, rd, wr, ea);
		ictim_exp_t e;
		int r;
		int k;
		int i;
		r = (ea != 0) ? $urandom_range(3) : 0;
		k = (ea != 0) ? 4 * r + 2 * $urandom_range(1) : 0;
		e.clks = 12'(clks + ((ea == 1) ? k : 0));
		e.rd = rd + ((ea == 1) ? r : 0);
		e.wr = wr;
		e.slow = slow;
		i = 0;
		do begin
			@(posedge clk_in);
			#2;
			i++;
		end while (ready !== 1'b1 && i < 3000);
		if (i >= 3000) n_mismatch++;
		op = o;
		sz = 2'(s);
		alt = a[0];
		cond = c[0];
		mem = m[0];
		nr = 5'(n);
		eac = 12'(k);
		ear = 8'(r);
		idx = 1'($urandom_range(1));
		req = 1'b1;
		expq.push_back(e);
		@(posedge clk_in);
		#2;
		req = 1'b0;
	endtask
	task automatic drain();
		for (int i = 0; i < 3000 && expq.size() != 0; i++) begin
			@(posedge clk_in);
		end
		@(posedge clk_in);
		#2;
	endtask
	// Main sequence
	initial begin
		int n;
		void'($urandom(32'h1dcb));
		repeat (10) @(posedge clk_in);
		#2;
		rstn_in = 1'b1;
		repeat (20) @(posedge clk_in);
		#2;
		hpin_n = 1'b1; // Start-up may begin only once halt is released
		run(ictim_pkg::OP_BRANCH_COND,0,0,1,0,0,18,4,0,0);
		run(ictim_pkg::OP_BRANCH_COND,1,0,1,0,0,18,4,0,0);
		run(ictim_pkg::OP_BRANCH_COND,0,0,0,0,0,12,2,0,0);
		run(ictim_pkg::OP_BRANCH_COND,1,0,0,0,0,20,4,0,0);
		run(ictim_pkg::OP_UNCOND_BRANCH,0,0,0,0,0,18,4,0,0);
		run(ictim_pkg::OP_UNCOND_BRANCH,1,0,0,0,0,18,4,0,0);
		run(ictim_pkg::OP_BRANCH_SUB,1,0,0,0,0,34,4,4,0);
		run(ictim_pkg::OP_DEC_BRANCH_LOOP,1,1,0,0,0,18,4,0,0);
		run(ictim_pkg::OP_DEC_BRANCH_LOOP,1,0,1,0,0,20,4,0,0);
		run(ictim_pkg::OP_DEC_BRANCH_LOOP,1,0,0,0,0,26,6,0,0);
		run(ictim_pkg::OP_BOUNDS_CHECK,1,0,1,0,0,68,8,6,1);
		run(ictim_pkg::OP_BOUNDS_CHECK,1,0,0,0,0,14,2,0,0);
		run(ictim_pkg::OP_SW_TRAP,0,0,1,0,0,62,8,6,0);
		run(ictim_pkg::OP_OVERFLOW_TRAP,0,0,1,0,0,66,10,6,0);
		run(ictim_pkg::OP_OVERFLOW_TRAP,0,0,0,0,0,8,2,0,0);
		run(ictim_pkg::OP_JUMP,0,0,0,0,0,16,4,0,0);
		run(ictim_pkg::OP_SUB_JUMP,0,0,0,0,0,32,4,4,0);
		run(ictim_pkg::OP_ADDR_LOAD,0,0,0,0,0,8,2,0,0);
		run(ictim_pkg::OP_ADDR_PUSH,0,0,0,0,0,24,2,4,0);
		// Register counts at both ends of the field, then one at random
		for (int j = 0; j < 3; j++) begin
			n = (j == 0) ? 0 : (j == 1) ? 31 : $urandom_range(30, 1);
			run(ictim_pkg::OP_MULTI_LOAD,1,0,0,0,n,24+8*n,6+2*n,0,0);
			run(ictim_pkg::OP_MULTI_LOAD,2,0,0,0,n,24+16*n,6+4*n,0,0);
			run(ictim_pkg::OP_MULTI_STORE,1,0,0,0,n,16+8*n,4,2*n,0);
			run(ictim_pkg::OP_MULTI_STORE,2,0,0,0,n,16+16*n,4,4*n,0);
		end
		run(ictim_pkg::OP_EXTENDED,0,0,0,0,0,8,2,0,0);
		run(ictim_pkg::OP_EXTENDED,1,0,0,0,0,8,2,0,0);
		run(ictim_pkg::OP_EXTENDED,2,0,0,0,0,12,2,0,0);
		run(ictim_pkg::OP_EXTENDED,0,0,0,1,0,22,4,1,0);
		run(ictim_pkg::OP_EXTENDED,1,0,0,1,0,50,6,2,0);
		run(ictim_pkg::OP_EXTENDED,2,0,0,1,0,58,10,4,0);
		run(ictim_pkg::OP_MEM_COMPARE,0,0,0,1,0,16,4,0,0);
		run(ictim_pkg::OP_MEM_COMPARE,1,0,0,1,0,24,6,0,0);
		run(ictim_pkg::OP_MEM_COMPARE,2,0,0,1,0,40,10,0,0);
		run(ictim_pkg::OP_DECIMAL,0,0,0,0,0,10,2,0,0);
		run(ictim_pkg::OP_DECIMAL,0,0,0,1,0,20,4,1,0);
		run(ictim_pkg::OP_IMM_TO_STATUS,1,0,0,0,0,32,6,0,0);
		run(ictim_pkg::OP_RET_EXCEPTION,0,0,0,0,0,40,10,0,0);
		run(ictim_pkg::OP_RET_SUB,0,0,0,0,0,32,8,0,0);
		run(ictim_pkg::OP_STOP,0,0,0,0,0,4,0,0,0);
		run(ictim_pkg::OP_NO_OPERATION,0,0,0,0,0,8,2,0,2);
		run(ictim_pkg::OP_RESET_LINE,0,0,0,0,0,136,2,0,0);
		@(posedge clk_in);
		#2;
		req = 1'b1; // Core is busy, so this request must be ignored
		@(posedge clk_in);
		#2;
		req = 1'b0;
		run(ictim_pkg::OP_FRAME_LINK,0,0,0,0,0,32,4,4,0);
		run(ictim_pkg::OP_FRAME_UNLINK,0,0,0,0,0,24,6,0,0);
		run(ictim_pkg::OP_LOAD_STATUS,1,0,0,0,0,18,4,0,0);
		run(ictim_pkg::OP_LOAD_STATUS,1,0,0,1,0,18,4,0,1);
		run(ictim_pkg::OP_READ_STATUS,1,0,0,0,0,10,2,0,0);
		run(ictim_pkg::OP_READ_STATUS,1,0,0,1,0,16,2,2,0);
		run(ictim_pkg::OP_USP_MOVE,2,0,0,0,0,8,2,0,0);
		run(ictim_pkg::OP_PERIPH_MOVE,1,1,0,0,0,24,4,2,0);
		run(ictim_pkg::OP_PERIPH_MOVE,2,1,0,0,0,32,4,4,0);
		run(ictim_pkg::OP_PERIPH_MOVE,1,0,0,0,0,24,6,0,0);
		run(ictim_pkg::OP_PERIPH_MOVE,2,0,0,0,0,32,8,0,0);
		run(ictim_pkg::OP_EXC_BUS_ERROR,0,0,0,0,0,94,8,14,0);
		run(ictim_pkg::OP_EXC_INTERRUPT,0,0,0,0,0,72,9,6,0);
		run(ictim_pkg::OP_EXC_GENERIC,0,0,0,0,0,62,8,6,0);
		run(ictim_pkg::OP_EXC_DIV_ZERO,1,0,0,0,0,66,8,6,1);
		drain();
		slow = 1'b1; // Slow memory: every total must grow by its wait clocks
		run(ictim_pkg::OP_BRANCH_SUB,1,0,0,0,0,34,4,4,0);
		run(ictim_pkg::OP_EXC_BUS_ERROR,0,0,0,0,0,94,8,14,0);
		drain();
		slow = 1'b0;
		rpin_n = 1'b0; // Pin reset must bring back the start-up sequence
		repeat (6) @(posedge clk_in);
		#2;
		rpin_n = 1'b1;
		run(ictim_pkg::OP_NO_OPERATION,0,0,0,0,0,8,2,0,0);
		drain();
		wrap_up();
	end
endmodule // instruction_cycle_timing_tb
